// ### shared/dtc_pkg.sv
// Shared constants, register map and carrier types of the dual 8-bit timer control block.
package dtc_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register indices on the register port.
  localparam logic [3:0] OFS_A_CONTROL     = 4'h0;
  localparam logic [3:0] OFS_A_PERIOD      = 4'h1;
  localparam logic [3:0] OFS_A_PULSE_WIDTH = 4'h2;
  localparam logic [3:0] OFS_B_CONTROL     = 4'h3;
  localparam logic [3:0] OFS_B_PERIOD      = 4'h4;
  localparam logic [3:0] OFS_B_PULSE_WIDTH = 4'h5;
  localparam logic [3:0] OFS_CONFIG        = 4'h6;
  localparam logic [3:0] OFS_COUNT_A       = 4'h7;
  localparam logic [3:0] OFS_COUNT_B       = 4'h8;
  localparam logic [3:0] OFS_STATUS        = 4'h9;

  // Field positions inside the configuration and status registers.
  localparam int unsigned CFG_DIV_SRC_BIT  = 0;
  localparam int unsigned STS_RUN_A_BIT    = 0;
  localparam int unsigned STS_RUN_B_BIT    = 1;
  localparam int unsigned STS_FLOP_A_BIT   = 2;
  localparam int unsigned STS_FLOP_B_BIT   = 3;
  localparam int unsigned STS_CASCADE_BIT  = 4;

  // Reset values and the counter's top value.
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIMER   = 8'h00;
  localparam logic [7:0] RST_COUNT   = 8'h00;
  localparam logic [7:0] COUNT_MAX   = 8'hFF;

  // Prescaler exponents of the high- and low-frequency dividers.
  localparam int unsigned FC_DIV_W     = 11;
  localparam int unsigned FS_DIV_W     = 3;

  // Clock-select codes.
  typedef enum logic [2:0] {
    CK_FC_D2048  = 3'h0,
    CK_FC_D128   = 3'h1,
    CK_FC_D32    = 3'h2,
    CK_FC_D8     = 3'h3,
    CK_FS        = 3'h4,
    CK_FC_D2     = 3'h5,
    CK_FC        = 3'h6,
    CK_PIN       = 3'h7
  } dtc_clk_sel_t;

  // Operating modes; timer A only uses the first four codes.
  typedef enum logic [2:0] {
    MD_TIMER8    = 3'h0,
    MD_DIVIDER_OUTPUT_MODE = 3'h1,
    MD_PWM8      = 3'h2,
    MD_CASCADE   = 3'h3,
    MD_TIMER16   = 3'h4,
    MD_WARMUP    = 3'h5,
    MD_PWM16     = 3'h6,
    MD_RSVD      = 3'h7
  } dtc_mode_t;

  // Layout of one timer control register, most significant field first.
  typedef struct packed {
    logic         flop_preset;
    dtc_clk_sel_t clock_select;
    logic         run;
    dtc_mode_t    mode_select;
  } dtc_ctl_t;

  // One-cycle tick strobes of every prescaled source.
  typedef struct packed {
    logic fc;
    logic fc_d2;
    logic fc_d8;
    logic fc_d32;
    logic fc_d128;
    logic fc_d2048;
    logic fs;
    logic fs_d8;
  } dtc_tick_t;

endpackage : dtc_pkg

// ### core/dtc_prescaler.sv
// Free-running high- and low-frequency prescaler producing one-cycle source ticks.
`timescale 1ns/1ps
module dtc_prescaler (
  input  wire logic              i_ref_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_fs_clk,
  output dtc_pkg::dtc_tick_t     o_ticks
);
  import dtc_pkg::*;

  logic [FC_DIV_W-1:0] fc_div_ff;
  logic [FC_DIV_W-1:0] nxt_fc_div;
  logic [FS_DIV_W-1:0] fs_div_ff;
  logic [FS_DIV_W-1:0] nxt_fs_div;
  logic                fs_prev_ff;
  logic                fs_rise;

  // The low-frequency clock is a slow level, so only its rising edge counts.
  always_comb begin
    fs_rise    = i_fs_clk & ~fs_prev_ff;
    nxt_fc_div = fc_div_ff + {{(FC_DIV_W-1){1'b0}}, 1'b1};
    nxt_fs_div = fs_rise ? fs_div_ff + {{(FS_DIV_W-1){1'b0}}, 1'b1} : fs_div_ff;
  end

  // Divider state.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      fc_div_ff  <= '0;
      fs_div_ff  <= '0;
      fs_prev_ff <= 1'b0;
    end else begin
      fc_div_ff  <= nxt_fc_div;
      fs_div_ff  <= nxt_fs_div;
      fs_prev_ff <= i_fs_clk;
    end
  end

  // A divide-by-2^k tick fires once the low k divider bits are all ones.
  always_comb begin
    o_ticks.fc       = 1'b1;
    o_ticks.fc_d2    = &fc_div_ff[0:0];
    o_ticks.fc_d8    = &fc_div_ff[2:0];
    o_ticks.fc_d32   = &fc_div_ff[4:0];
    o_ticks.fc_d128  = &fc_div_ff[6:0];
    o_ticks.fc_d2048 = &fc_div_ff[10:0];
    o_ticks.fs       = fs_rise;
    o_ticks.fs_d8    = fs_rise & (&fs_div_ff);
  end

endmodule : dtc_prescaler

// ### core/dtc_clk_sel.sv
// Source-clock selector of one timer, including the external pin edge detector.
`timescale 1ns/1ps
module dtc_clk_sel (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_sys_rst,
  input  wire dtc_pkg::dtc_clk_sel_t i_sel,
  input  wire dtc_pkg::dtc_tick_t    i_ticks,
  input  wire logic                  i_pin,
  input  wire logic                  i_low_speed,
  input  wire logic                  i_div_src,
  input  wire logic                  i_warmup,
  output logic                       o_tick
);
  import dtc_pkg::*;

  logic pin_prev_ff;
  logic pin_rise;

  // External pin counts on its rising edge.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pin_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= i_pin;
    end
  end

  // In the low-speed modes the fast prescaler taps give no tick, except fc during warm-up; the fc/2048 code takes fs/8 instead.
  always_comb begin
    pin_rise = i_pin & ~pin_prev_ff;
    case (i_sel)
      CK_FC_D2048: o_tick = (i_div_src | i_low_speed) ? i_ticks.fs_d8 : i_ticks.fc_d2048;
      CK_FC_D128:  o_tick = i_ticks.fc_d128 & ~i_low_speed;
      CK_FC_D32:   o_tick = i_ticks.fc_d32 & ~i_low_speed;
      CK_FC_D8:    o_tick = i_ticks.fc_d8 & ~i_low_speed;
      CK_FS:       o_tick = i_ticks.fs;
      CK_FC_D2:    o_tick = i_ticks.fc_d2 & ~i_low_speed;
      CK_FC:       o_tick = i_ticks.fc & (~i_low_speed | i_warmup);
      CK_PIN:      o_tick = pin_rise;
      default:     o_tick = 1'b0;
    endcase
  end

endmodule : dtc_clk_sel

// ### core/dtc_top.sv
// Dual 8-bit timer control: register file, source selection, cascade and counters.
//
// Operation
// - Each timer: control, period, pulse-width registers.
// - Timer A clock-select code picks source.
// - Low-speed modes restrict fast clock codes.
// - Run bit 0 stops and clears; 1 starts.
// - Timer A mode: divider, PWM, cascaded 16-bit; only cascade (011) is decoded, no divider or PWM output here.
// - Cascade: A mode 011, B gives mode.
// - Cascade: A clock, B run and flop.
// - Timer B clock codes match timer A.
// - Flop preset bit clears or sets output flop.
// - Timer B mode codes for 8/16-bit modes.
// - Upper-byte modes count timer A overflow.
`timescale 1ns/1ps
module dtc_top (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic [dtc_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [dtc_pkg::DATA_W-1:0]  i_wr_data,
  input  wire logic                        i_wr_en,
  input  wire logic                        i_rd_en,
  input  wire logic                        i_fs_clk,
  input  wire logic                        i_timer_a_pin,
  input  wire logic                        i_timer_b_pin,
  input  wire logic                        i_low_speed,
  output logic      [dtc_pkg::DATA_W-1:0]  o_rd_data,
  output logic                             o_timer_a_flop,
  output logic                             o_timer_b_flop,
  output logic                             o_timer_a_running,
  output logic                             o_timer_b_running
);
  import dtc_pkg::*;

  // Software-visible registers.
  dtc_ctl_t    timer_a_control_ff;
  dtc_ctl_t    nxt_timer_a_control;
  dtc_ctl_t    timer_b_control_ff;
  dtc_ctl_t    nxt_timer_b_control;
  logic [7:0]  timer_a_period_ff;
  logic [7:0]  nxt_timer_a_period;
  logic [7:0]  timer_a_pulse_width_ff;
  logic [7:0]  nxt_timer_a_pulse_width;
  logic [7:0]  timer_b_period_ff;
  logic [7:0]  nxt_timer_b_period;
  logic [7:0]  timer_b_pulse_width_ff;
  logic [7:0]  nxt_timer_b_pulse_width;
  logic        divider_source_select_ff;
  logic        nxt_divider_source_select;

  // Counting state.
  logic [7:0]  count_a_ff;
  logic [7:0]  nxt_count_a;
  logic [7:0]  count_b_ff;
  logic [7:0]  nxt_count_b;
  logic        flop_a_ff;
  logic        nxt_flop_a;
  logic        flop_b_ff;
  logic        nxt_flop_b;

  // Read port and running outputs.
  logic [7:0]  rd_data_ff;
  logic [7:0]  nxt_rd_data;
  logic        run_a_ff;
  logic        run_b_ff;

  // Derived control.
  dtc_tick_t   ticks;
  logic        cascaded;
  logic        run_a;
  logic        run_b;
  logic        preset_a;
  logic        warmup;
  logic        sel_tick_a;
  logic        sel_tick_b;
  logic        tick_b;
  logic        overflow_a;

  // Register writes are plain stores; keeping period and pulse width steady
  // while a timer runs is up to software, so the block does not lock them.
  always_comb begin
    nxt_timer_a_control       = timer_a_control_ff;
    nxt_timer_b_control       = timer_b_control_ff;
    nxt_timer_a_period        = timer_a_period_ff;
    nxt_timer_a_pulse_width   = timer_a_pulse_width_ff;
    nxt_timer_b_period        = timer_b_period_ff;
    nxt_timer_b_pulse_width   = timer_b_pulse_width_ff;
    nxt_divider_source_select = divider_source_select_ff;
    if (i_wr_en) begin
      case (i_addr)
        OFS_A_CONTROL:     nxt_timer_a_control       = dtc_ctl_t'(i_wr_data);
        OFS_A_PERIOD:      nxt_timer_a_period        = i_wr_data;
        OFS_A_PULSE_WIDTH: nxt_timer_a_pulse_width   = i_wr_data;
        OFS_B_CONTROL:     nxt_timer_b_control       = dtc_ctl_t'(i_wr_data);
        OFS_B_PERIOD:      nxt_timer_b_period        = i_wr_data;
        OFS_B_PULSE_WIDTH: nxt_timer_b_pulse_width   = i_wr_data;
        OFS_CONFIG:        nxt_divider_source_select = i_wr_data[CFG_DIV_SRC_BIT];
        default:           nxt_divider_source_select = divider_source_select_ff;
      endcase
    end
  end

  // Register file storage.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      timer_a_control_ff       <= dtc_ctl_t'(RST_CONTROL);
      timer_b_control_ff       <= dtc_ctl_t'(RST_CONTROL);
      timer_a_period_ff        <= RST_TIMER;
      timer_a_pulse_width_ff   <= RST_TIMER;
      timer_b_period_ff        <= RST_TIMER;
      timer_b_pulse_width_ff   <= RST_TIMER;
      divider_source_select_ff <= 1'b0;
    end else begin
      timer_a_control_ff       <= nxt_timer_a_control;
      timer_b_control_ff       <= nxt_timer_b_control;
      timer_a_period_ff        <= nxt_timer_a_period;
      timer_a_pulse_width_ff   <= nxt_timer_a_pulse_width;
      timer_b_period_ff        <= nxt_timer_b_period;
      timer_b_pulse_width_ff   <= nxt_timer_b_pulse_width;
      divider_source_select_ff <= nxt_divider_source_select;
    end
  end

  // Cascade takes run and flop preset from timer B, clock from timer A.
  // Timer A's own run bit is ignored while cascaded, so software need only
  // start timer B; this avoids the two halves starting on different edges.
  always_comb begin
    cascaded = (timer_a_control_ff.mode_select == MD_CASCADE);
    run_a    = cascaded ? timer_b_control_ff.run : timer_a_control_ff.run;
    run_b    = timer_b_control_ff.run;
    preset_a = cascaded ? timer_b_control_ff.flop_preset
                        : timer_a_control_ff.flop_preset;
    warmup   = (timer_b_control_ff.mode_select == MD_WARMUP);
  end

  // Shared prescaler for both timers.
  dtc_prescaler u_prescaler (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_fs_clk  (i_fs_clk),
    .o_ticks   (ticks)
  );

  // Timer A source clock, also the cascade's clock.
  dtc_clk_sel u_clk_sel_a (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_sel       (timer_a_control_ff.clock_select),
    .i_ticks     (ticks),
    .i_pin       (i_timer_a_pin),
    .i_low_speed (i_low_speed),
    .i_div_src   (divider_source_select_ff),
    .i_warmup    (warmup),
    .o_tick      (sel_tick_a)
  );

  // Timer B source clock with the same encoding.
  dtc_clk_sel u_clk_sel_b (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_sel       (timer_b_control_ff.clock_select),
    .i_ticks     (ticks),
    .i_pin       (i_timer_b_pin),
    .i_low_speed (i_low_speed),
    .i_div_src   (divider_source_select_ff),
    .i_warmup    (warmup),
    .o_tick      (sel_tick_b)
  );

  // Timer A overflow feeds the upper byte in the same cycle, so the 16-bit
  // count carries without a one-tick lag.
  always_comb begin
    overflow_a = run_a & sel_tick_a & (count_a_ff == COUNT_MAX);
    tick_b     = timer_b_control_ff.mode_select[2] ? overflow_a : sel_tick_b;
  end

  // Counters clear while stopped and advance one step per source tick.
  always_comb begin
    nxt_count_a = count_a_ff;
    nxt_count_b = count_b_ff;
    if (!run_a) begin
      nxt_count_a = RST_COUNT;
    end else if (sel_tick_a) begin
      nxt_count_a = count_a_ff + 8'h01;
    end
    if (!run_b) begin
      nxt_count_b = RST_COUNT;
    end else if (tick_b) begin
      nxt_count_b = count_b_ff + 8'h01;
    end
  end

  // Output flops follow their preset while the timer is stopped and hold
  // once it runs; waveform generation sits outside this block.
  always_comb begin
    nxt_flop_a = run_a ? flop_a_ff : preset_a;
    nxt_flop_b = run_b ? flop_b_ff : timer_b_control_ff.flop_preset;
  end

  // Counting state storage.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      count_a_ff <= RST_COUNT;
      count_b_ff <= RST_COUNT;
      flop_a_ff  <= 1'b0;
      flop_b_ff  <= 1'b0;
      run_a_ff   <= 1'b0;
      run_b_ff   <= 1'b0;
    end else begin
      count_a_ff <= nxt_count_a;
      count_b_ff <= nxt_count_b;
      flop_a_ff  <= nxt_flop_a;
      flop_b_ff  <= nxt_flop_b;
      run_a_ff   <= run_a;
      run_b_ff   <= run_b;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads give zero.
  always_comb begin
    nxt_rd_data = 8'h00;
    if (i_rd_en) begin
      case (i_addr)
        OFS_A_CONTROL:     nxt_rd_data = timer_a_control_ff;
        OFS_A_PERIOD:      nxt_rd_data = timer_a_period_ff;
        OFS_A_PULSE_WIDTH: nxt_rd_data = timer_a_pulse_width_ff;
        OFS_B_CONTROL:     nxt_rd_data = timer_b_control_ff;
        OFS_B_PERIOD:      nxt_rd_data = timer_b_period_ff;
        OFS_B_PULSE_WIDTH: nxt_rd_data = timer_b_pulse_width_ff;
        OFS_CONFIG:        nxt_rd_data[CFG_DIV_SRC_BIT] = divider_source_select_ff;
        OFS_COUNT_A:       nxt_rd_data = count_a_ff;
        OFS_COUNT_B:       nxt_rd_data = count_b_ff;
        OFS_STATUS: begin
          nxt_rd_data[STS_RUN_A_BIT]   = run_a;
          nxt_rd_data[STS_RUN_B_BIT]   = run_b;
          nxt_rd_data[STS_FLOP_A_BIT]  = flop_a_ff;
          nxt_rd_data[STS_FLOP_B_BIT]  = flop_b_ff;
          nxt_rd_data[STS_CASCADE_BIT] = cascaded;
        end
        default:           nxt_rd_data = 8'h00;
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Outputs come straight from flip-flops.
  always_comb begin
    o_rd_data         = rd_data_ff;
    o_timer_a_flop    = flop_a_ff;
    o_timer_b_flop    = flop_b_ff;
    o_timer_a_running = run_a_ff;
    o_timer_b_running = run_b_ff;
  end

endmodule : dtc_top

// ### tb/dtc_properties.sv
// Port-level assertions of the dual timer control block.
`timescale 1ns/1ps
module dtc_properties
  import dtc_pkg::*;
(
  input wire logic                        i_ref_clk,
  input wire logic                        i_sys_rst,
  input wire logic [dtc_pkg::ADDR_W-1:0]  i_addr,
  input wire logic [dtc_pkg::DATA_W-1:0]  i_wr_data,
  input wire logic                        i_wr_en,
  input wire logic                        i_rd_en,
  input wire logic [dtc_pkg::DATA_W-1:0]  o_rd_data,
  input wire logic                        o_timer_a_flop,
  input wire logic                        o_timer_b_flop,
  input wire logic                        o_timer_a_running,
  input wire logic                        o_timer_b_running
);
  dtc_ctl_t ctl_a_ff;
  dtc_ctl_t ctl_b_ff;
  dtc_ctl_t nxt_ctl_a;
  dtc_ctl_t nxt_ctl_b;
  logic     casc;
  logic     eff_a;
  logic     pre_a;

  // Shadow control registers rebuilt from port writes, so run and preset can be predicted.
  always_comb begin
    nxt_ctl_a = ctl_a_ff;
    nxt_ctl_b = ctl_b_ff;
    if (i_wr_en && i_addr == OFS_A_CONTROL) nxt_ctl_a = dtc_ctl_t'(i_wr_data);
    if (i_wr_en && i_addr == OFS_B_CONTROL) nxt_ctl_b = dtc_ctl_t'(i_wr_data);
  end

  // Registered copies cleared by the synchronous reset.
  always_ff @(posedge i_ref_clk) begin
    ctl_a_ff <= i_sys_rst ? dtc_ctl_t'(RST_CONTROL) : nxt_ctl_a;
    ctl_b_ff <= i_sys_rst ? dtc_ctl_t'(RST_CONTROL) : nxt_ctl_b;
  end

  // In cascade the first timer borrows run and preset from the second.
  assign casc  = ctl_a_ff.mode_select == MD_CASCADE;
  assign eff_a = casc ? ctl_b_ff.run : ctl_a_ff.run;
  assign pre_a = casc ? ctl_b_ff.flop_preset : ctl_a_ff.flop_preset;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_rd_idle_zero: assert property (!$past(i_rd_en) |-> o_rd_data == '0)
    else $error("read data not zero outside read slot");
  a_reset_clears: assert property (disable iff (1'b0) i_sys_rst |=> o_rd_data == '0
    && !o_timer_a_flop && !o_timer_b_flop && !o_timer_a_running && !o_timer_b_running)
    else $error("outputs not cleared by reset");
  a_ctl_readback: assert property ((i_wr_en && i_addr == OFS_A_CONTROL) ##1
    (i_rd_en && i_addr == OFS_A_CONTROL) |=> o_rd_data == $past(i_wr_data, 2))
    else $error("control read back differs from write");
  a_run_a_follows: assert property (o_timer_a_running == $past(eff_a))
    else $error("timer a run output wrong");
  a_run_b_follows: assert property (o_timer_b_running == $past(ctl_b_ff.run))
    else $error("timer b run output wrong");
  a_flop_a_preset: assert property ($past(!eff_a, 2) && $past(!eff_a) && $stable(pre_a)
    && $past(pre_a) == $past(pre_a, 2) |-> o_timer_a_flop == pre_a)
    else $error("timer a flop not at preset while stopped");
  a_flop_b_preset: assert property ($past(!ctl_b_ff.run, 2) && $past(!ctl_b_ff.run)
    && $stable(ctl_b_ff) |-> o_timer_b_flop == ctl_b_ff.flop_preset)
    else $error("timer b flop not at preset while stopped");
  a_flop_a_holds: assert property ($past(eff_a, 2) && $past(eff_a) && eff_a
    |-> $stable(o_timer_a_flop))
    else $error("timer a flop moved while running");
  a_status_run: assert property ($past(i_rd_en && i_addr == OFS_STATUS)
    |-> o_rd_data[STS_RUN_A_BIT] == $past(eff_a) && o_rd_data[STS_CASCADE_BIT] == $past(casc))
    else $error("status run or cascade bit wrong");
  a_count_cleared: assert property ($past(i_rd_en && i_addr == OFS_COUNT_A && !eff_a)
    && $past(!eff_a, 2) |-> o_rd_data == RST_COUNT)
    else $error("stopped counter not cleared");
endmodule : dtc_properties

bind dtc_top dtc_properties i_props (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .o_rd_data(o_rd_data), .o_timer_a_flop(o_timer_a_flop), .o_timer_b_flop(o_timer_b_flop),
  .o_timer_a_running(o_timer_a_running), .o_timer_b_running(o_timer_b_running));

// ### tb/dual_8bit_timer_control_test.sv
// Self-checking bench of the dual timer control block.
`timescale 1ns/1ps
module dual_8bit_timer_control_test;
  import dtc_pkg::*;
  logic              i_ref_clk = 1'b0;
  logic              i_sys_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wr_data = '0;
  logic              i_wr_en = 1'b0;
  logic              i_rd_en = 1'b0;
  logic              i_fs_clk = 1'b0;
  logic              i_timer_a_pin = 1'b0;
  logic              i_timer_b_pin = 1'b0;
  logic              i_low_speed = 1'b0;
  logic [DATA_W-1:0] o_rd_data;
  logic              o_timer_a_flop;
  logic              o_timer_b_flop;
  logic              o_timer_a_running;
  logic              o_timer_b_running;
  logic [2:0]        fs_div = 3'h0;
  int                mismatches = 0;
  int                checks = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  // Slow clock with a rising edge every eight cycles keeps fs-based rates exactly periodic.
  always @(posedge i_ref_clk) begin
    fs_div <= fs_div + 3'h1;
    i_fs_clk <= fs_div[2];
  end

  dtc_top i_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_fs_clk(i_fs_clk),
    .i_timer_a_pin(i_timer_a_pin), .i_timer_b_pin(i_timer_b_pin), .i_low_speed(i_low_speed),
    .o_rd_data(o_rd_data), .o_timer_a_flop(o_timer_a_flop), .o_timer_b_flop(o_timer_b_flop),
    .o_timer_a_running(o_timer_a_running), .o_timer_b_running(o_timer_b_running));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_ref_clk);
    i_wr_en <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are sampled just then.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    #1;
    d = o_rd_data;
  endtask : rd

  // Write immediately followed by a read of the same place, with no idle cycle between.
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] exp);
    wr(a, d);
    i_rd_en <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    #1;
    check(o_rd_data, exp);
  endtask : wr_rd

  // Two count reads whose strobes are gap cycles apart; the difference is the tick count.
  task automatic measure(input logic [3:0] a, input int gap, input logic [7:0] exp);
    logic [7:0] c0;
    logic [7:0] c1;
    rd(a, c0);
    repeat (gap - 2) @(posedge i_ref_clk);
    rd(a, c1);
    check(c1 - c0, exp);
  endtask : measure

  // Start one timer on a source, count ticks, then stop with fields unchanged and expect zero.
  task automatic run_rate(input logic t, input logic [2:0] code, input int gap,
                          input logic [7:0] exp);
    logic [7:0] c;
    wr(t ? OFS_B_CONTROL : OFS_A_CONTROL, {1'b0, code, 1'b1, 3'h0});
    measure(t ? OFS_COUNT_B : OFS_COUNT_A, gap, exp);
    wr(t ? OFS_B_CONTROL : OFS_A_CONTROL, {1'b0, code, 1'b0, 3'h0});
    rd(t ? OFS_COUNT_B : OFS_COUNT_A, c);
    check(c, RST_COUNT);
  endtask : run_rate

  task automatic test_regs();
    logic [7:0] d;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), d);
      check(d, RST_CONTROL);
    end
    wr_rd(OFS_A_PERIOD, 8'h5A, 8'h5A);
    wr_rd(OFS_A_PULSE_WIDTH, 8'hA5, 8'hA5);
    wr_rd(OFS_B_PERIOD, 8'hC3, 8'hC3);
    wr_rd(OFS_B_PULSE_WIDTH, 8'h3C, 8'h3C);
    wr_rd(OFS_COUNT_A, 8'hFF, RST_COUNT);
    wr_rd(4'hF, 8'hFF, 8'h00);
    for (int m = 0; m < 8; m++) begin
      wr_rd(OFS_B_CONTROL, {5'h1E, 3'(m)}, {5'h1E, 3'(m)});
      if (m < 4) wr_rd(OFS_A_CONTROL, {5'h1E, 3'(m)}, {5'h1E, 3'(m)});
    end
    wr(OFS_A_CONTROL, RST_CONTROL);
    wr(OFS_B_CONTROL, RST_CONTROL);
  endtask : test_regs

  // Each source code but the pin of both timers, over gaps that are whole periods of that source.
  task automatic test_rates();
    logic [2:0] code [7] = '{3'h6, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4};
    int         gap [7]  = '{16, 16, 64, 128, 512, 4096, 64};
    logic [7:0] exp [7]  = '{8'h10, 8'h08, 8'h08, 8'h04, 8'h04, 8'h02, 8'h08};
    for (int t = 0; t < 2; t++) begin
      for (int i = 0; i < 7; i++) run_rate(t[0], code[i], gap[i], exp[i]);
    end
    wr(OFS_CONFIG, 8'h01);
    run_rate(1'b0, 3'h0, 512, 8'h08);
    run_rate(1'b1, 3'h0, 512, 8'h08);
    wr(OFS_CONFIG, 8'h00);
  endtask : test_rates

  // Fast codes die in low-speed mode, fc/2048 falling back to fs/8; fc survives only for warm-up.
  task automatic test_low_speed();
    logic [2:0] code [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h0, 3'h6};
    int         gap [6]  = '{256, 256, 256, 256, 512, 64};
    logic [7:0] exp [6]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
    @(posedge i_ref_clk);
    i_low_speed <= 1'b1;
    for (int i = 0; i < 6; i++) run_rate(1'b0, code[i], gap[i], exp[i]);
    wr(OFS_B_CONTROL, {5'h00, MD_WARMUP});
    run_rate(1'b0, 3'h6, 16, 8'h10);
    wr(OFS_B_CONTROL, RST_CONTROL);
    i_low_speed <= 1'b0;
  endtask : test_low_speed

  // Distinct pulse counts on the two pins expose a swapped or dead pin path.
  task automatic test_pin();
    logic [7:0] d;
    wr(OFS_A_CONTROL, 8'h78);
    wr(OFS_B_CONTROL, 8'h78);
    for (int i = 0; i < 5; i++) begin
      i_timer_a_pin <= 1'b1;
      i_timer_b_pin <= (i < 3);
      repeat (3) @(posedge i_ref_clk);
      i_timer_a_pin <= 1'b0;
      i_timer_b_pin <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
    end
    rd(OFS_COUNT_A, d);
    check(d, 8'h05);
    rd(OFS_COUNT_B, d);
    check(d, 8'h03);
    wr(OFS_A_CONTROL, 8'h70);
    wr(OFS_B_CONTROL, 8'h70);
  endtask : test_pin

  // Cascade: first timer clocked by fc but started by the second, which counts its wraps.
  task automatic test_cascade();
    logic [7:0] d;
    wr(OFS_B_CONTROL, 8'hE4);
    wr(OFS_A_CONTROL, 8'h63);
    wr(OFS_B_CONTROL, 8'hEC);
    rd(OFS_STATUS, d);
    check(d, 8'h1F);
    check({6'h00, o_timer_b_running, o_timer_a_running}, 8'h03);
    // Timer B's own fc select would count every cycle if the overflow path were bypassed.
    measure(OFS_COUNT_B, 512, 8'h02);
    wr(OFS_B_CONTROL, 8'hE4);
    repeat (3) @(posedge i_ref_clk);
    #1;
    check({7'h00, o_timer_a_flop}, 8'h01);
    rd(OFS_COUNT_A, d);
    check(d, RST_COUNT);
    wr(OFS_A_CONTROL, RST_CONTROL);
    wr(OFS_B_CONTROL, RST_CONTROL);
  endtask : test_cascade

  task automatic test_flop();
    for (int v = 1; v >= 0; v--) begin
      wr(OFS_A_CONTROL, {v[0], 7'h00});
      wr(OFS_B_CONTROL, {v[0], 7'h00});
      repeat (3) @(posedge i_ref_clk);
      #1;
      check({6'h00, o_timer_b_flop, o_timer_a_flop}, {6'h00, v[0], v[0]});
    end
  endtask : test_flop

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog that ends a hung run as a mismatch.
  initial begin
    repeat (100000) @(posedge i_ref_clk);
    mismatches++;
    $display("[FAIL] %0t run did not finish", $time);
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    test_regs();
    test_rates();
    test_low_speed();
    test_pin();
    test_cascade();
    test_flop();
    tally_and_finish();
  end
endmodule : dual_8bit_timer_control_test
